// File: rtl/indexed_register_access_port.sv
// Purpose: index port and data port into registers, post ram and value ram
// Assumes: one host access per cycle; serial master reports busy as a level
// Notes:   read data valid on rdata_q two cycles after the data port read
//
// Behaviour
// - index port bits 6 to 0 hold the index that selects data port target.
// - index port bit 7 is read-only busy, set by index write or serial transfer.
// - busy from index write clears on next data access; serial busy clears at end.
// - index resets to zero.
// - access at first event flags register moves index to the second.
// - access at first system management mask moves index to the second.
// - access at first non-maskable mask moves index to the second.
// - post ram at 00 to 1F, index advances per access and holds at 1F.
// - upper value ram at 60 to 7F, index advances and stops at 7F.
// - registers take listed reset values; fan divisor high nibble fixed at 5, low nibble follows voltage inputs.
// - each event flags register clears when read.
`timescale 1ns/100ps
`default_nettype none
`include "index_port_cfg.svh"
module indexed_register_access_port #(
    parameter int IW = 7,
    parameter logic [7:0] CHIP_ID = 8'h00  // arbitrary identity value
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       bus_sel,
    input  wire logic       bus_wr,
    input  wire logic       bus_rd,
    input  wire logic [7:0] bus_wdata,
    input  wire logic       serial_busy,
    input  wire logic [7:0] event_one_in,
    input  wire logic [7:0] event_two_in,
    input  wire logic [3:0] voltage_id_inputs,
    output var  logic [7:0] rdata_q,
    output var  logic [7:0] config_q,
    output var  logic [7:0] smi_mask_one_q,
    output var  logic [7:0] smi_mask_two_q,
    output var  logic [7:0] nmi_mask_one_q,
    output var  logic [7:0] nmi_mask_two_q,
    output var  logic [7:0] ser_addr_q
);
    // ==================================================================
    // pin synchronisers
    logic [1:0] sbusy_sync_q;
    logic [3:0] vid_s1_q, vid_s2_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sbusy_sync_q <= 2'b00;
            vid_s1_q     <= 4'h0;
            vid_s2_q     <= 4'h0;
        end else begin
            sbusy_sync_q <= {sbusy_sync_q[0], serial_busy};
            vid_s1_q     <= voltage_id_inputs;
            vid_s2_q     <= vid_s1_q;
        end
    end
    logic sbusy;
    assign sbusy = sbusy_sync_q[1];

    // ==================================================================
    // decode
    function automatic logic in_range(input logic [6:0] i, input logic [6:0] lo,
                                      input logic [6:0] hi);
        in_range = (i >= lo) && (i <= hi);
    endfunction : in_range

    logic [IW-1:0] index_q, index_d;
    index_port_pkg::busy_src_t busy_q, busy_d;
    logic [7:0] ev_one_q, ev_one_d, ev_two_q, ev_two_d;
    logic [7:0] cfg_d, sm1_d, sm2_d, nm1_d, nm2_d, sa_d;
    logic [7:0] reg_rd_q, reg_rd_d, ram_rdata;
    logic       sel_ram_q, sel_ram_d, rd_pend_q, rd_pend_d;
    logic [7:0] out_d;
    logic       idx_wr, dat_wr, dat_rd, dat_acc, ram_hit, ram_we, init;

    assign idx_wr  = bus_sel == `PORT_INDEX && bus_wr;
    assign dat_wr  = bus_sel == `PORT_DATA && bus_wr;
    assign dat_rd  = bus_sel == `PORT_DATA && bus_rd;
    assign dat_acc = dat_wr || dat_rd;
    assign ram_hit = index_q <= `IDX_VRAM_LO_LAST || index_q >= `IDX_VRAM_HI_FIRST;
    assign ram_we  = dat_wr && ram_hit;
    assign init    = dat_wr && index_q == `IDX_CONFIG && bus_wdata[`CFG_INIT_BIT];

    value_ram #(.AW(IW), .DW(8)) u_ram (
        .mclk    (mclk),
        .we      (ram_we),
        .addr    (index_q),
        .wdata   (bus_wdata),
        .rdata_q (ram_rdata)
    );

    // ==================================================================
    // next state
    always_comb begin
        index_d   = index_q;
        busy_d    = busy_q;
        ev_one_d  = ev_one_q | event_one_in;
        ev_two_d  = ev_two_q | event_two_in;
        cfg_d     = config_q;
        sm1_d     = smi_mask_one_q;
        sm2_d     = smi_mask_two_q;
        nm1_d     = nmi_mask_one_q;
        nm2_d     = nmi_mask_two_q;
        sa_d      = ser_addr_q;
        reg_rd_d  = reg_rd_q;
        sel_ram_d = sel_ram_q;
        rd_pend_d = dat_rd;
        out_d     = rdata_q;
        // busy tracking
        if (sbusy) begin
            busy_d = index_port_pkg::BUSY_SERIAL;
        end else if (idx_wr) begin
            busy_d = index_port_pkg::BUSY_HOST;
        end else if (busy_q == index_port_pkg::BUSY_SERIAL
                     || (busy_q == index_port_pkg::BUSY_HOST && dat_acc)) begin
            busy_d = index_port_pkg::BUSY_IDLE;
        end
        // index port
        if (idx_wr) begin
            index_d = bus_wdata[IW-1:0];
        end else if (bus_sel == `PORT_INDEX && bus_rd) begin
            out_d = {busy_q != index_port_pkg::BUSY_IDLE, index_q};
        end
        // data port
        if (dat_acc) begin
            sel_ram_d = ram_hit;
            if (index_q == `IDX_EVENT_ONE || index_q == `IDX_SMI_MASK_ONE
                || index_q == `IDX_NMI_MASK_ONE) begin
                index_d = index_q + 7'h01;
            end else if (index_q < `IDX_POST_LAST) begin
                index_d = index_q + 7'h01;
            end else if (in_range(index_q, `IDX_VRAM_HI_FIRST, 7'h7E)) begin
                index_d = index_q + 7'h01;
            end else begin
                index_d = index_q;
            end
        end
        if (dat_rd) begin
            case (index_q)
                `IDX_CONFIG:       reg_rd_d = config_q;
                `IDX_EVENT_ONE: begin
                    reg_rd_d = ev_one_q;
                    ev_one_d = event_one_in;
                end
                `IDX_EVENT_TWO: begin
                    reg_rd_d = ev_two_q;
                    ev_two_d = event_two_in;
                end
                `IDX_SMI_MASK_ONE: reg_rd_d = smi_mask_one_q;
                `IDX_SMI_MASK_TWO: reg_rd_d = smi_mask_two_q;
                `IDX_NMI_MASK_ONE: reg_rd_d = nmi_mask_one_q;
                `IDX_NMI_MASK_TWO: reg_rd_d = nmi_mask_two_q;
                `IDX_VID_FAN:      reg_rd_d = {`RST_FAN_DIV_HI, vid_s2_q};
                `IDX_SER_ADDR:     reg_rd_d = ser_addr_q;
                `IDX_CHIP_ID:      reg_rd_d = CHIP_ID;
                default:           reg_rd_d = 8'h00;
            endcase
        end
        if (dat_wr) begin
            case (index_q)
                `IDX_CONFIG:       cfg_d = bus_wdata & 8'h7F;
                `IDX_SMI_MASK_ONE: sm1_d = bus_wdata;
                `IDX_SMI_MASK_TWO: sm2_d = bus_wdata;
                `IDX_NMI_MASK_ONE: nm1_d = bus_wdata;
                `IDX_NMI_MASK_TWO: nm2_d = bus_wdata;
                `IDX_SER_ADDR:     sa_d  = bus_wdata;
                default:           cfg_d = config_q;
            endcase
        end
        // software init restores defaults except serial address
        if (init) begin
            cfg_d    = `RST_CONFIG;
            // events landing with the init write are kept: set wins over clear
            ev_one_d = `RST_EVENT | event_one_in;
            ev_two_d = `RST_EVENT | event_two_in;
            sm1_d    = `RST_MASK;
            sm2_d    = `RST_MASK;
            nm1_d    = `RST_MASK;
            nm2_d    = `RST_NMI_MASK_TWO;
        end
        // read data lands one cycle after the ram or register capture
        if (rd_pend_q) begin
            out_d = sel_ram_q ? ram_rdata : reg_rd_q;
        end
    end

    // ==================================================================
    // registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            index_q        <= `RST_INDEX;
            busy_q         <= index_port_pkg::BUSY_IDLE;
            ev_one_q       <= `RST_EVENT;
            ev_two_q       <= `RST_EVENT;
            config_q       <= `RST_CONFIG;
            smi_mask_one_q <= `RST_MASK;
            smi_mask_two_q <= `RST_MASK;
            nmi_mask_one_q <= `RST_MASK;
            nmi_mask_two_q <= `RST_NMI_MASK_TWO;
            ser_addr_q     <= `RST_SER_ADDR;
            reg_rd_q       <= 8'h00;
            sel_ram_q      <= 1'b0;
            rd_pend_q      <= 1'b0;
            rdata_q        <= 8'h00;
        end else begin
            index_q        <= index_d;
            busy_q         <= busy_d;
            ev_one_q       <= ev_one_d;
            ev_two_q       <= ev_two_d;
            config_q       <= cfg_d;
            smi_mask_one_q <= sm1_d;
            smi_mask_two_q <= sm2_d;
            nmi_mask_one_q <= nm1_d;
            nmi_mask_two_q <= nm2_d;
            ser_addr_q     <= sa_d;
            reg_rd_q       <= reg_rd_d;
            sel_ram_q      <= sel_ram_d;
            rd_pend_q      <= rd_pend_d;
            rdata_q        <= out_d;
        end
    end

    // ==================================================================
    // checks
    a_index_write: assert property (@(posedge mclk) disable iff (rst)
        idx_wr |=> index_q == $past(bus_wdata[6:0]))
        else $error("index not loaded");
    a_busy_set: assert property (@(posedge mclk) disable iff (rst)
        idx_wr |=> busy_q != index_port_pkg::BUSY_IDLE)
        else $error("busy not set");
    a_busy_clear: assert property (@(posedge mclk) disable iff (rst)
        busy_q == index_port_pkg::BUSY_HOST && dat_acc && !idx_wr && !sbusy
        |=> busy_q == index_port_pkg::BUSY_IDLE)
        else $error("busy not cleared");
    a_pair_step: assert property (@(posedge mclk) disable iff (rst)
        dat_acc && !idx_wr && index_q == `IDX_EVENT_ONE
        |=> index_q == `IDX_EVENT_TWO)
        else $error("event pair step");
    a_smi_step: assert property (@(posedge mclk) disable iff (rst)
        dat_acc && !idx_wr && index_q == `IDX_SMI_MASK_ONE
        |=> index_q == `IDX_SMI_MASK_TWO)
        else $error("smi pair step");
    a_nmi_step: assert property (@(posedge mclk) disable iff (rst)
        dat_acc && !idx_wr && index_q == `IDX_NMI_MASK_ONE
        |=> index_q == `IDX_NMI_MASK_TWO)
        else $error("nmi pair step");
    a_post_hold: assert property (@(posedge mclk) disable iff (rst)
        dat_acc && !idx_wr && index_q == `IDX_POST_LAST
        |=> index_q == `IDX_POST_LAST)
        else $error("post end moved");
    a_vram_stop: assert property (@(posedge mclk) disable iff (rst)
        dat_acc && !idx_wr && index_q == `IDX_VRAM_HI_LAST
        |=> index_q == `IDX_VRAM_HI_LAST)
        else $error("vram end moved");
    a_clear_read: assert property (@(posedge mclk) disable iff (rst)
        dat_rd && index_q == `IDX_EVENT_ONE |=> ev_one_q == $past(event_one_in))
        else $error("flags not cleared");
    a_lo_vram: assert property (@(posedge mclk) disable iff (rst)
        dat_acc && !idx_wr && in_range(index_q, `IDX_VRAM_LO_FIRST, `IDX_VRAM_LO_LAST)
        |=> $stable(index_q))
        else $error("index moved");
    c_post_walk: cover property (@(posedge mclk) disable iff (rst)
        dat_wr && index_q == `IDX_POST_LAST);
    c_pair_read: cover property (@(posedge mclk) disable iff (rst)
        dat_rd && index_q == `IDX_EVENT_ONE ##1 dat_rd);
    c_serial_busy: cover property (@(posedge mclk) disable iff (rst)
        busy_q == index_port_pkg::BUSY_SERIAL);
endmodule : indexed_register_access_port
`default_nettype wire

// File: rtl/index_port_cfg.svh
// Purpose: offsets, field positions, reset values of the indexed register port
// Assumes: byte-wide data, seven-bit index
// Notes:   definitions only
`ifndef INDEX_PORT_CFG_SVH
`define INDEX_PORT_CFG_SVH
// ==================================================================
// port selects and index map
`define PORT_INDEX          1'b0
`define PORT_DATA           1'b1
`define IDX_POST_LAST       7'h1F
`define IDX_VRAM_LO_FIRST   7'h20
`define IDX_VRAM_LO_LAST    7'h3F
`define IDX_CONFIG          7'h40
`define IDX_EVENT_ONE       7'h41
`define IDX_EVENT_TWO       7'h42
`define IDX_SMI_MASK_ONE    7'h43
`define IDX_SMI_MASK_TWO    7'h44
`define IDX_NMI_MASK_ONE    7'h45
`define IDX_NMI_MASK_TWO    7'h46
`define IDX_VID_FAN         7'h47
`define IDX_SER_ADDR        7'h48
`define IDX_CHIP_ID         7'h49
`define IDX_VRAM_HI_FIRST   7'h60
`define IDX_VRAM_HI_LAST    7'h7F
// ==================================================================
// fields and reset values
`define BUSY_BIT            7
`define CFG_INIT_BIT        7
`define RST_INDEX           7'h00
`define RST_CONFIG          8'h08
`define RST_EVENT           8'h00
`define RST_MASK            8'h00
`define RST_NMI_MASK_TWO    8'h40
`define RST_FAN_DIV_HI      4'h5
`define RST_SER_ADDR        8'h2D
`endif

// File: rtl/index_port_pkg.sv
// Purpose: shared types of the indexed register port
// Assumes: nothing
// Notes:   none
package index_port_pkg;
    typedef enum logic [1:0] {
        BUSY_IDLE   = 2'b00,
        BUSY_HOST   = 2'b01,
        BUSY_SERIAL = 2'b11
    } busy_src_t;
endpackage : index_port_pkg

// File: rtl/value_ram.sv
// Purpose: byte memory for post codes and measured values
// Assumes: single port, read data registered
// Notes:   contents undefined after reset
`timescale 1ns/100ps
`default_nettype none
module value_ram #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input  wire logic          mclk,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output var  logic [DW-1:0] rdata_q
);
    logic [DW-1:0] mem [2**AW];
    // ==================================================================
    // storage
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_q <= mem[addr];
    end
endmodule : value_ram
`default_nettype wire

// File: tb/serial_master_model.sv
// Purpose: serial bus master stand-in, holds the transfer level for len cycles
// Assumes: bench pulses go only while the host bus is idle
// Notes:   len picks a prompt or a slow transfer
`timescale 1ns/100ps
`default_nettype none
module serial_master_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire logic [3:0] len,
    output var  logic       serial_busy
);
    // ==========================================================
    // transfer length counter
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    always_comb begin
        cnt_d = cnt_q;
        if (cnt_q != 4'h0) begin
            cnt_d = cnt_q - 4'h1;
        end else if (go) begin
            cnt_d = len;
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    always_comb begin
        serial_busy = (cnt_q != 4'h0);
    end
endmodule : serial_master_model
`default_nettype wire

// File: tb/indexed_register_access_port_tb_top.sv
// Purpose: self-checking bench of the indexed register port
// Assumes: results checked late; rdata_q holds until the next read
// Notes:   fixed seed, random data among hand-picked corners
`timescale 1ns/100ps
`default_nettype none
module indexed_register_access_port_tb_top;
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic       bus_sel = 1'b0;
    logic       bus_wr = 1'b0;
    logic       bus_rd = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic       serial_busy;
    logic       go = 1'b0;
    logic [7:0] ev1 = 8'h00;
    logic [7:0] ev2 = 8'h00;
    logic [3:0] vid = 4'h0;
    logic [7:0] rdata_q, config_q, smi1, smi2, nmi1, nmi2, ser_addr_q;
    logic [6:0] ix, b;
    logic [7:0] d1, d2, d3;
    int         n_fail = 0;
    int         check_count = 0;
    int         r;
    always #2 mclk = ~mclk;
    // ==========================================================
    // instances
    serial_master_model sm (.mclk(mclk), .rst(rst), .go(go), .len(4'hF),
        .serial_busy(serial_busy));
    indexed_register_access_port dut (.mclk(mclk), .rst(rst), .bus_sel(bus_sel),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
        .serial_busy(serial_busy), .event_one_in(ev1), .event_two_in(ev2),
        .voltage_id_inputs(vid), .rdata_q(rdata_q), .config_q(config_q),
        .smi_mask_one_q(smi1), .smi_mask_two_q(smi2), .nmi_mask_one_q(nmi1),
        .nmi_mask_two_q(nmi2), .ser_addr_q(ser_addr_q));
    // ==========================================================
    // expectation and bus tasks
    function automatic logic [6:0] nxt(input logic [6:0] i);
        if (i == 7'h41 || i == 7'h43 || i == 7'h45) return i + 7'h01;
        if (i < 7'h1F || (i >= 7'h60 && i < 7'h7F)) return i + 7'h01;
        return i;  // ranges stop at their last place
    endfunction : nxt
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic s, input logic w, input logic [7:0] d);
        @(posedge mclk);
        #1;
        bus_sel = s;
        bus_wr = w;
        bus_rd = !w;
        bus_wdata = d;
        @(posedge mclk);
        #1;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    endtask : acc
    // checked two edges late so both read latencies have landed
    task automatic rd(input logic s, input logic [7:0] exp);
        acc(s, 1'b0, 8'h00);
        repeat (2) @(posedge mclk);
        #1 chk(rdata_q, exp);
    endtask : rd
    task automatic set(input logic [6:0] i);
        acc(1'b0, 1'b1, {1'b0, i});
        ix = i;
    endtask : set
    task automatic drd(input logic [7:0] exp);
        rd(1'b1, exp);
        ix = nxt(ix);
    endtask : drd
    task automatic dwr(input logic [7:0] d);
        acc(1'b1, 1'b1, d);
        ix = nxt(ix);
    endtask : dwr
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    // ==========================================================
    // tests
    initial begin
        #40000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        r = $urandom(86463);
        vid = 4'($urandom);
        repeat (8) @(posedge mclk);
        #1 rst = 1'b0;
        chk(config_q, 8'h08);
        chk(nmi2, 8'h40);
        chk(ser_addr_q, 8'h2D);
        chk(smi1 | smi2 | nmi1, 8'h00);
        rd(1'b0, 8'h00);
        set(7'h40);
        rd(1'b0, 8'hC0);
        drd(8'h08);
        rd(1'b0, {1'b0, ix});
        set(7'h47);
        drd({4'h5, vid});
        for (int k = 0; k < 2; k++) begin
            d1 = 8'($urandom);
            d2 = 8'($urandom) & 8'h7F;
            set(k ? 7'h45 : 7'h43);
            dwr(d1);
            rd(1'b0, {1'b0, ix});
            dwr(d2);
            chk(k ? nmi1 : smi1, d1);
            chk(k ? nmi2 : smi2, d2);
        end
        d1 = 8'($urandom) | 8'h01;
        d2 = 8'($urandom);
        @(posedge mclk);
        #1 ev1 = d1;
        ev2 = d2;
        @(posedge mclk);
        #1 ev1 = 8'h00;
        ev2 = 8'h00;
        set(7'h41);
        drd(d1);
        rd(1'b0, 8'h42);
        drd(d2);
        set(7'h41);
        drd(8'h00);
        for (int k = 0; k < 2; k++) begin
            b = k ? 7'h7E : 7'h1E;
            d1 = 8'($urandom);
            d2 = 8'($urandom);
            d3 = 8'($urandom);
            set(b);
            dwr(d1);
            dwr(d2);
            dwr(d3);
            rd(1'b0, {1'b0, ix});
            set(b);
            drd(d1);
            drd(d3);
        end
        for (int k = 0; k < 6; k++) begin
            d1 = 8'($urandom);
            set(7'h20 + 7'($urandom % 32));
            dwr(d1);
            rd(1'b0, {1'b0, ix});
            drd(d1);
        end
        set(7'h48);
        dwr(d1);
        chk(ser_addr_q, d1);
        set(7'h43);
        dwr(8'hFF);
        set(7'h40);
        dwr(8'h80 | 8'($urandom));
        chk(config_q, 8'h08);
        chk(smi1 | smi2 | nmi1, 8'h00);
        chk(nmi2, 8'h40);
        chk(ser_addr_q, d1);
        @(posedge mclk);
        #1 go = 1'b1;
        @(posedge mclk);
        #1 go = 1'b0;
        repeat (5) @(posedge mclk);
        rd(1'b0, {1'b1, ix});
        repeat (12) @(posedge mclk);
        rd(1'b0, {1'b0, ix});
        @(posedge mclk);
        #1 rst = 1'b1;
        repeat (3) @(posedge mclk);
        #1 rst = 1'b0;
        chk(ser_addr_q, 8'h2D);
        rd(1'b0, 8'h00);
        tally_and_finish();
    end
endmodule : indexed_register_access_port_tb_top
`default_nettype wire
